// ===== include/cifs_defs.svh
/*
 * Bit positions, fixed read values and counts for the CAN interrupt flag
 * and sleep block. Assumes inclusion by bare name from any design file.
 */
`ifndef CIFS_DEFS_SVH
`define CIFS_DEFS_SVH

// Interrupt flag register layout
`define CIFS_VEC_MSB        4
`define CIFS_VEC_LSB        0
`define CIFS_WLIF_BIT       8
`define CIFS_EPIF_BIT       9
`define CIFS_BOIF_BIT       10
`define CIFS_OVW_BIT        11
`define CIFS_WUIF_BIT       12
`define CIFS_WDIF_BIT       13
`define CIFS_ABORT_BIT      14
`define CIFS_MBOX_BIT       15
`define CIFS_TCOF_BIT       16
`define CIFS_MTOF_BIT       17

// Master control and error status fields
`define CIFS_WAKE_EN_BIT    7
`define CIFS_PDR_BIT        11
`define CIFS_SLEEP_ACK_BIT  3

// Reset and power-down read values
`define CIFS_PD_STATUS_VAL  32'h0000_0008
`define CIFS_PD_OTHER_VAL   32'h0000_0000
`define CIFS_ZERO32         32'h0000_0000

// Recessive bits needed before going bus-active after a bus wake-up
`define CIFS_IDLE_BITS      11

`endif

// ===== include/cifs_pkg.sv
/*
 * Types shared by the CAN interrupt flag and sleep block.
 * Assumes a 32-mailbox controller; no other dependencies.
 */
package cifs_pkg;

   // Power-down sequencing states
   typedef enum logic [1:0] {
      PD_RUN,
      PD_PEND,
      PD_SLEEP,
      PD_WAKE
   } cifs_pd_state_e;

   // Register selected by a read
   typedef enum logic [3:0] {
      RD_FLAG0,
      RD_FLAG1,
      RD_STATUS,
      RD_MCTL,
      RD_TA,
      RD_RMP,
      RD_AA,
      RD_RML,
      RD_TOS
   } cifs_rd_sel_e;

   // System event pulses, also used for the stored flags
   typedef struct packed {
      logic stamp_overflow;
      logic write_denied;
      logic busoff;
      logic err_passive;
      logic warn_level;
   } cifs_sys_evt_s;

   // Per-mailbox event pulses from the datapath
   typedef struct packed {
      logic [31:0] tx_done;
      logic [31:0] rx_done;
      logic [31:0] abort_done;
      logic [31:0] timeout;
   } cifs_mbox_evt_s;

   // Software write-one-to-clear strobes, per mailbox
   typedef struct packed {
      logic [31:0] ta;
      logic [31:0] rx_pending_bits;
      logic [31:0] aa;
      logic [31:0] rx_lost_bits;
      logic [31:0] timeout_status_bits;
   } cifs_mbox_clr_s;

endpackage

// ===== hdl/cifs_prio_enc.sv
/*
 * Priority encoder: reports the highest-numbered pending mailbox.
 * Assumes request bits are already masked and routed to one line.
 */
`timescale 1ns/1ps
`default_nettype none

module cifs_prio_enc
(
   input  wire logic [31:0] req,
   output logic             any,
   output logic [4:0]       vec
);

   // Higher mailbox number wins
   always_comb
   begin
      vec = 5'h00;
      for (int i = 0; i < 32; i++)
      begin
         if (req[i])
         begin
            vec = 5'(i);
         end
      end
      any = |req;
   end

endmodule

`default_nettype wire

// ===== hdl/cifs_idle_det.sv
/*
 * Counts consecutive recessive bits on the receive pin after a bus wake-up.
 * Assumes bit_tick pulses once per bit time, in the bit's sample point.
 */
`timescale 1ns/1ps
`default_nettype none
`include "cifs_defs.svh"

module cifs_idle_det
#(
   parameter int unsigned IDLE_BITS = `CIFS_IDLE_BITS
)
(
   input  wire logic sys_clk,
   input  wire logic srst,
   input  wire logic run,
   input  wire logic bit_tick,
   input  wire logic bus_rx_pin,
   output logic      done_r
);

   logic [4:0] cnt_r;

   // Dominant bit restarts the count, idle state clears it
   always_ff @(posedge sys_clk)
   begin
      if (srst || !run)
      begin
         cnt_r  <= 5'h00;
         done_r <= 1'b0;
      end
      else if (bit_tick)
      begin
         if (!bus_rx_pin)
         begin
            cnt_r <= 5'h00;
         end
         else if (cnt_r != 5'(IDLE_BITS))
         begin
            cnt_r <= cnt_r + 5'h01;
         end
         done_r <= bus_rx_pin && (cnt_r == 5'(IDLE_BITS - 1));
      end
      else
      begin
         done_r <= 1'b0;
      end
   end

endmodule

`default_nettype wire

// ===== hdl/cifs_top.sv
/*
 * CAN interrupt flags, flag clearing and local power-down control.
 * Assumes the mailbox datapath drives event pulses, software write-one
 * strobes arrive as one-cycle masks, and sys_clk is the always-on clock.
 */
// Summary of operation
// - Mailbox event sets flag and vector
// - Mailbox flag at bit 15, sign bit
// - Abort bit 14, overwrite bit 11
// - Overwrite sets overwrite and mailbox flags
// - System flags cleared by writing one
// - Timeout flag cleared via timeout status
// - Mailbox flag cleared via ack/pending bits
// - Abort flag cleared via abort ack
// - Overwrite flag cleared via pending bit
// - Ack and pending bits write-one-clear
// - Power-down request finishes packet, acks
// - Asleep reads give 0x08 or zero
// - Wake on request clear or bus
// - Eleven recessive bits before bus-active after bus wake
// - Wake-up frame is discarded
// - Leaving sleep clears request and ack
// - Ongoing transmission ends before ack
// - Always-on clock plus gated clock
// - Peripheral clock gate, off after reset
// - Leaving sleep sets wake-up flag
// - Line routing by select bits
// - Vector shows highest-priority mailbox
// - Line released when nothing pending
`timescale 1ns/1ps
`default_nettype none
`include "cifs_defs.svh"

module cifs_top
#(
   parameter int unsigned IDLE_BITS = `CIFS_IDLE_BITS
)
(
   input  wire logic                   sys_clk,
   input  wire logic                   srst,
   input  wire logic                   periph_clk_en,
   input  wire cifs_pkg::cifs_mbox_evt_s mbox_evt,
   input  wire cifs_pkg::cifs_sys_evt_s  sys_evt,
   input  wire cifs_pkg::cifs_mbox_clr_s mbox_clr,
   input  wire logic [31:0]            flag0_w1c,
   input  wire logic [31:0]            flag1_w1c,
   input  wire logic [31:0]            mbox_irq_mask,
   input  wire logic [31:0]            mbox_line_select,
   input  wire logic                   system_irq_line_select,
   input  wire logic                   bus_wake_enable,
   input  wire logic                   pdr_wr,
   input  wire logic                   pdr_wdata,
   input  wire logic                   tx_busy,
   input  wire logic                   bit_tick,
   input  wire logic                   bus_rx_pin,
   input  wire logic                   rd_en,
   input  wire cifs_pkg::cifs_rd_sel_e rd_sel,
   output logic [31:0]                 rd_data_r,
   output logic [1:0]                  irq_line_r,
   output logic                        powerdown_request_r,
   output logic                        sleep_ack_r,
   output logic                        core_clk_en_r,
   output logic                        bus_active_r,
   output logic                        frame_discard_r
);

   cifs_pkg::cifs_pd_state_e st_r;
   cifs_pkg::cifs_sys_evt_s  sysf_r;
   logic        wake_flag_r;
   logic [31:0] ta_r, rmp_r, aa_r, rml_r, tos_r, ovw_src_r;
   logic [31:0] ovw, masked, mb0, mb1, sys_clr;
   logic [31:0] flag0_c, flag1_c;
   logic [4:0]  vec0, vec1;
   logic        any0, any1, run, enter_sleep, leave, bus_wake, idle_done;

   // Builds one interrupt flag word for a line
   function automatic logic [31:0] build_flag(
      input logic                    any_mb,
      input logic [4:0]              vec,
      input logic                    mto,
      input logic                    sys_here,
      input logic                    abt,
      input logic                    ovf,
      input logic                    wuf,
      input cifs_pkg::cifs_sys_evt_s sf);
      logic [31:0] w;
      w = `CIFS_ZERO32;
      w[`CIFS_MBOX_BIT] = any_mb;
      w[`CIFS_VEC_MSB:`CIFS_VEC_LSB] = any_mb ? vec : 5'h00;
      w[`CIFS_MTOF_BIT] = mto;
      if (sys_here)
      begin
         w[`CIFS_ABORT_BIT] = abt;
         w[`CIFS_OVW_BIT]   = ovf;
         w[`CIFS_WUIF_BIT]  = wuf;
         w[`CIFS_TCOF_BIT]  = sf.stamp_overflow;
         w[`CIFS_WDIF_BIT]  = sf.write_denied;
         w[`CIFS_BOIF_BIT]  = sf.busoff;
         w[`CIFS_EPIF_BIT]  = sf.err_passive;
         w[`CIFS_WLIF_BIT]  = sf.warn_level;
      end
      return w;
   endfunction

   // Mailbox bits and stored system event flags update only with the peripheral clock on and awake
   assign run = periph_clk_en && (st_r != cifs_pkg::PD_SLEEP);

   // Overwrite: new reception into a still-pending mailbox
   assign ovw = mbox_evt.rx_done & rmp_r & ~(mbox_clr.rx_pending_bits & {32{run}});

   // Transmit acknowledge bits, set wins over clear
   always_ff @(posedge sys_clk)
   begin
      if (srst)
         ta_r <= `CIFS_ZERO32;
      else if (run)
         ta_r <= (ta_r & ~mbox_clr.ta) | mbox_evt.tx_done;
   end

   // Receive pending bits, set wins over clear
   always_ff @(posedge sys_clk)
   begin
      if (srst)
         rmp_r <= `CIFS_ZERO32;
      else if (run)
         rmp_r <= (rmp_r & ~mbox_clr.rx_pending_bits) | mbox_evt.rx_done;
   end

   // Lost-message bits and overwrite sources
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         rml_r     <= `CIFS_ZERO32;
         ovw_src_r <= `CIFS_ZERO32;
      end
      else if (run)
      begin
         rml_r     <= (rml_r & ~mbox_clr.rx_lost_bits) | ovw;
         ovw_src_r <= (ovw_src_r & ~mbox_clr.rx_pending_bits) | ovw;
      end
   end

   // Abort acknowledge and timeout status bits
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         aa_r  <= `CIFS_ZERO32;
         tos_r <= `CIFS_ZERO32;
      end
      else if (run)
      begin
         aa_r  <= (aa_r & ~mbox_clr.aa) | mbox_evt.abort_done;
         tos_r <= (tos_r & ~mbox_clr.timeout_status_bits) | mbox_evt.timeout;
      end
   end

   // Mailbox routing to the two lines
   assign masked = (ta_r | rmp_r) & mbox_irq_mask;
   assign mb0    = masked & ~mbox_line_select;
   assign mb1    = masked & mbox_line_select;

   cifs_prio_enc u_enc0
   (
      .req (mb0),
      .any (any0),
      .vec (vec0)
   );

   cifs_prio_enc u_enc1
   (
      .req (mb1),
      .any (any1),
      .vec (vec1)
   );

   // System flags clear only by a one written to the line they sit on
   assign sys_clr = system_irq_line_select ? flag1_w1c : flag0_w1c;

   always_ff @(posedge sys_clk)
   begin
      if (srst)
         sysf_r <= '0;
      else if (run)
      begin
         sysf_r.stamp_overflow <= sys_evt.stamp_overflow
                                  || (sysf_r.stamp_overflow && !sys_clr[`CIFS_TCOF_BIT]);
         sysf_r.write_denied   <= sys_evt.write_denied
                                  || (sysf_r.write_denied && !sys_clr[`CIFS_WDIF_BIT]);
         sysf_r.busoff         <= sys_evt.busoff
                                  || (sysf_r.busoff && !sys_clr[`CIFS_BOIF_BIT]);
         sysf_r.err_passive    <= sys_evt.err_passive
                                  || (sysf_r.err_passive && !sys_clr[`CIFS_EPIF_BIT]);
         sysf_r.warn_level     <= sys_evt.warn_level
                                  || (sysf_r.warn_level && !sys_clr[`CIFS_WLIF_BIT]);
      end
   end

   // Wake-up flag, set on leaving sleep, set wins over clear
   always_ff @(posedge sys_clk)
   begin
      if (srst)
         wake_flag_r <= 1'b0;
      else if (leave)
         wake_flag_r <= 1'b1;
      else if (run && sys_clr[`CIFS_WUIF_BIT])
         wake_flag_r <= 1'b0;
   end

   // Flag words for both lines
   assign flag0_c = build_flag(any0, vec0, |(tos_r & ~mbox_line_select),
                               !system_irq_line_select, |aa_r, |ovw_src_r,
                               wake_flag_r, sysf_r);
   assign flag1_c = build_flag(any1, vec1, |(tos_r & mbox_line_select),
                               system_irq_line_select, |aa_r, |ovw_src_r,
                               wake_flag_r, sysf_r);

   // Interrupt lines follow their flag words
   always_ff @(posedge sys_clk)
   begin
      if (srst)
         irq_line_r <= 2'h0;
      else
         irq_line_r <= {|flag1_c, |flag0_c};
   end

   // Sleep entry and exit conditions
   assign enter_sleep = powerdown_request_r && !tx_busy
                        && ((st_r == cifs_pkg::PD_RUN) || (st_r == cifs_pkg::PD_PEND));
   assign bus_wake    = (st_r == cifs_pkg::PD_SLEEP) && powerdown_request_r
                        && bus_wake_enable && !bus_rx_pin;
   assign leave       = (st_r == cifs_pkg::PD_SLEEP)
                        && (!powerdown_request_r || bus_wake);

   // Power-down sequencer on the always-on clock
   always_ff @(posedge sys_clk)
   begin
      if (srst)
         st_r <= cifs_pkg::PD_RUN;
      else
      begin
         unique case (st_r)
            cifs_pkg::PD_RUN:
               if (powerdown_request_r)
                  st_r <= tx_busy ? cifs_pkg::PD_PEND : cifs_pkg::PD_SLEEP;
            cifs_pkg::PD_PEND:
               if (!powerdown_request_r)
                  st_r <= cifs_pkg::PD_RUN;
               else if (!tx_busy)
                  st_r <= cifs_pkg::PD_SLEEP;
            cifs_pkg::PD_SLEEP:
               if (bus_wake)
                  st_r <= cifs_pkg::PD_WAKE;
               else if (!powerdown_request_r)
                  st_r <= cifs_pkg::PD_RUN;
            cifs_pkg::PD_WAKE:
               if (idle_done)
                  st_r <= cifs_pkg::PD_RUN;
         endcase
      end
   end

   cifs_idle_det #(.IDLE_BITS(IDLE_BITS)) u_idle
   (
      .sys_clk    (sys_clk),
      .srst       (srst),
      .run        (st_r == cifs_pkg::PD_WAKE),
      .bit_tick   (bit_tick),
      .bus_rx_pin (bus_rx_pin),
      .done_r     (idle_done)
   );

   // Request bit: software write, hardware clear on leaving
   always_ff @(posedge sys_clk)
   begin
      if (srst)
         powerdown_request_r <= 1'b0;
      else if (pdr_wr)
         powerdown_request_r <= pdr_wdata;
      else if (leave)
         powerdown_request_r <= 1'b0;
   end

   // Acknowledge and link status
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         sleep_ack_r     <= 1'b0;
         bus_active_r    <= 1'b0;
         frame_discard_r <= 1'b0;
         core_clk_en_r   <= 1'b0;
      end
      else
      begin
         if (enter_sleep)
            sleep_ack_r <= 1'b1;
         else if (leave)
            sleep_ack_r <= 1'b0;
         bus_active_r    <= (st_r == cifs_pkg::PD_RUN) || (st_r == cifs_pkg::PD_PEND);
         frame_discard_r <= bus_wake || ((st_r == cifs_pkg::PD_WAKE) && !idle_done);
         core_clk_en_r   <= periph_clk_en && !enter_sleep
                            && ((st_r != cifs_pkg::PD_SLEEP) || leave);
      end
   end

   // Read port; fixed values while asleep, contents untouched
   always_ff @(posedge sys_clk)
   begin
      if (srst)
         rd_data_r <= `CIFS_ZERO32;
      else if (rd_en)
      begin
         if (st_r == cifs_pkg::PD_SLEEP)
            rd_data_r <= (rd_sel == cifs_pkg::RD_STATUS) ? `CIFS_PD_STATUS_VAL
                                                         : `CIFS_PD_OTHER_VAL;
         else
         begin
            unique case (rd_sel)
               cifs_pkg::RD_FLAG0:  rd_data_r <= flag0_c;
               cifs_pkg::RD_FLAG1:  rd_data_r <= flag1_c;
               cifs_pkg::RD_STATUS: rd_data_r <= 32'(sleep_ack_r) << `CIFS_SLEEP_ACK_BIT;
               cifs_pkg::RD_MCTL:   rd_data_r <= (32'(powerdown_request_r) << `CIFS_PDR_BIT)
                                                 | (32'(bus_wake_enable) << `CIFS_WAKE_EN_BIT);
               cifs_pkg::RD_TA:     rd_data_r <= ta_r;
               cifs_pkg::RD_RMP:    rd_data_r <= rmp_r;
               cifs_pkg::RD_AA:     rd_data_r <= aa_r;
               cifs_pkg::RD_RML:    rd_data_r <= rml_r;
               cifs_pkg::RD_TOS:    rd_data_r <= tos_r;
               default:             rd_data_r <= `CIFS_ZERO32;
            endcase
         end
      end
   end

   // Checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);

   sequence s_sleep_req;
      (st_r == cifs_pkg::PD_RUN) && powerdown_request_r && !tx_busy && !pdr_wr;
   endsequence

   sequence s_asleep;
      (st_r == cifs_pkg::PD_SLEEP) && sleep_ack_r;
   endsequence

   property p_mbox_line0;
      run && |(mbox_evt.rx_done & mbox_irq_mask & ~mbox_line_select)
      |-> ##2 irq_line_r[0];
   endproperty
   a_mbox_line0: assert property (p_mbox_line0) else $error("line 0 not raised");

   property p_vec_prio;
      any0 |-> mb0[vec0] && ((mb0 >> vec0) == 32'h0000_0001);
   endproperty
   a_vec_prio: assert property (p_vec_prio) else $error("vector not highest");

   property p_sign_read;
      rd_en && (rd_sel == cifs_pkg::RD_FLAG0) && (st_r != cifs_pkg::PD_SLEEP) && any0
      |=> rd_data_r[`CIFS_MBOX_BIT] && (rd_data_r[4:0] == $past(vec0));
   endproperty
   a_sign_read: assert property (p_sign_read) else $error("mailbox flag read wrong");

   property p_ovw;
      run && |ovw |=> (|ovw_src_r) && (|rmp_r);
   endproperty
   a_ovw: assert property (p_ovw) else $error("overwrite not flagged");

   property p_busoff_hold;
      run && sysf_r.busoff && !sys_clr[`CIFS_BOIF_BIT] |=> sysf_r.busoff;
   endproperty
   a_busoff_hold: assert property (p_busoff_hold) else $error("busoff lost");

   property p_tos_hold;
      (|tos_r) && (mbox_clr.timeout_status_bits == 32'h0000_0000) |=> |tos_r;
   endproperty
   a_tos_hold: assert property (p_tos_hold) else $error("timeout lost");

   property p_sleep_entry;
      s_sleep_req |=> s_asleep ##1 (!core_clk_en_r)[*2];
   endproperty
   a_sleep_entry: assert property (p_sleep_entry) else $error("sleep not entered");

   property p_tx_hold;
      (st_r == cifs_pkg::PD_PEND) && tx_busy |=> !sleep_ack_r;
   endproperty
   a_tx_hold: assert property (p_tx_hold) else $error("ack during transmit");

   property p_pd_read;
      rd_en && (st_r == cifs_pkg::PD_SLEEP)
      |=> rd_data_r == (($past(rd_sel) == cifs_pkg::RD_STATUS) ? 32'h0000_0008 : 32'h0000_0000);
   endproperty
   a_pd_read: assert property (p_pd_read) else $error("asleep read wrong");

   property p_leave;
      leave && !pdr_wr |=> !powerdown_request_r && !sleep_ack_r && wake_flag_r;
   endproperty
   a_leave: assert property (p_leave) else $error("leave not clean");

   property p_wake_wait;
      (st_r == cifs_pkg::PD_WAKE) && !idle_done |=> (st_r == cifs_pkg::PD_WAKE) && frame_discard_r;
   endproperty
   a_wake_wait: assert property (p_wake_wait) else $error("woke too early");

   property p_release;
      !(|flag0_c) |=> !irq_line_r[0];
   endproperty
   a_release: assert property (p_release) else $error("line 0 held");

endmodule

`default_nettype wire

// ===== tb/cifs_bus_model.sv
/*
 * Far-side bus model: free-running bit tick and one short frame on request.
 * Assumes the bus idles recessive (high) and go is a one-cycle pulse.
 */
`timescale 1ns/1ps
`default_nettype none

module cifs_bus_model
(
   input  wire logic sys_clk,
   input  wire logic go,
   output logic      bit_tick,
   output logic      bus_rx_pin,
   output var logic  frame_busy_r
);
   localparam logic [7:0] FRAME = 8'hB2;
   logic [1:0] div_r = 2'h0;
   logic [3:0] idx_r = 4'h0;
   logic       pend_r = 1'b0;

   initial frame_busy_r = 1'b0;

   // Bit time of four clocks
   assign bit_tick = (div_r == 2'h3);

   // Frame sequencing, one bit per tick, last bit recessive
   always @(posedge sys_clk)
   begin
      div_r <= div_r + 2'h1;
      if (bit_tick && frame_busy_r)
      begin
         if (idx_r == 4'h7)
            frame_busy_r <= 1'b0;
         idx_r <= idx_r + 4'h1;
      end
      else if (bit_tick && pend_r)
      begin
         frame_busy_r <= 1'b1;
         idx_r        <= 4'h0;
      end
      if (go)
         pend_r <= 1'b1;
      else if (bit_tick && !frame_busy_r)
         pend_r <= 1'b0;
   end

   // Recessive when no frame is on the wire
   assign bus_rx_pin = frame_busy_r ? FRAME[idx_r[2:0]] : 1'b1;
endmodule
`default_nettype wire

// ===== tb/cifs_top_tb_top.sv
/*
 * Self-checking bench for the interrupt flag and sleep block.
 * Assumes the bus model file and the design package are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

module cifs_top_tb_top;
   logic sys_clk, srst, periph_clk_en, sys_sel, wake_en, pdr_wr, pdr_wdata, tx_busy, rd_en, go;
   logic [31:0] f0_w1c, f1_w1c, mask, line_sel, rd_data_r;
   logic [1:0]  irq_line_r;
   logic pdr_r, ack_r, core_en_r, active_r, discard_r, bit_tick, rx_pin, fbusy;
   cifs_pkg::cifs_mbox_evt_s mbox_evt;
   cifs_pkg::cifs_sys_evt_s  sys_evt;
   cifs_pkg::cifs_mbox_clr_s mbox_clr;
   cifs_pkg::cifs_rd_sel_e   rd_sel;
   int fail_count, cmp_count;

   cifs_top uut (.sys_clk(sys_clk), .srst(srst), .periph_clk_en(periph_clk_en),
      .mbox_evt(mbox_evt), .sys_evt(sys_evt), .mbox_clr(mbox_clr), .flag0_w1c(f0_w1c),
      .flag1_w1c(f1_w1c), .mbox_irq_mask(mask), .mbox_line_select(line_sel),
      .system_irq_line_select(sys_sel), .bus_wake_enable(wake_en), .pdr_wr(pdr_wr),
      .pdr_wdata(pdr_wdata), .tx_busy(tx_busy), .bit_tick(bit_tick), .bus_rx_pin(rx_pin),
      .rd_en(rd_en), .rd_sel(rd_sel), .rd_data_r(rd_data_r), .irq_line_r(irq_line_r),
      .powerdown_request_r(pdr_r), .sleep_ack_r(ack_r), .core_clk_en_r(core_en_r),
      .bus_active_r(active_r), .frame_discard_r(discard_r));

   cifs_bus_model bus (.sys_clk(sys_clk), .go(go), .bit_tick(bit_tick),
      .bus_rx_pin(rx_pin), .frame_busy_r(fbusy));

   // 50 MHz clock
   initial
   begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   task tally_and_finish;
      $display("Checks %0d, errors %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         $display("Error %s expected %h seen %h", nm, exp, got);
         fail_count++;
      end
   endtask

   // Read with a mask on the compared bits
   task rd(input cifs_pkg::cifs_rd_sel_e s, input logic [31:0] exp, input logic [31:0] m);
      @(posedge sys_clk);
      rd_en  <= 1'b1;
      rd_sel <= s;
      @(posedge sys_clk);
      rd_en <= 1'b0;
      #1;
      chk(s.name(), exp, rd_data_r & m);
   endtask

   // Mailbox event: 0 tx, 1 rx, 2 abort, 3 timeout
   task mev(input int f, input int n);
      cifs_pkg::cifs_mbox_evt_s e;
      e = '0;
      case (f)
         0: e.tx_done[n] = 1'b1;
         1: e.rx_done[n] = 1'b1;
         2: e.abort_done[n] = 1'b1;
         default: e.timeout[n] = 1'b1;
      endcase
      @(posedge sys_clk);
      mbox_evt <= e;
      @(posedge sys_clk);
      mbox_evt <= '0;
   endtask

   // Per-mailbox clear: 0 ta, 1 rmp, 2 aa, 3 rml, 4 tos
   task mclr(input int f, input int n);
      cifs_pkg::cifs_mbox_clr_s c;
      c = '0;
      case (f)
         0: c.ta[n] = 1'b1;
         1: c.rx_pending_bits[n] = 1'b1;
         2: c.aa[n] = 1'b1;
         3: c.rx_lost_bits[n] = 1'b1;
         default: c.timeout_status_bits[n] = 1'b1;
      endcase
      @(posedge sys_clk);
      mbox_clr <= c;
      @(posedge sys_clk);
      mbox_clr <= '0;
   endtask

   task w1c(input logic [31:0] v);
      @(posedge sys_clk);
      f0_w1c <= v;
      @(posedge sys_clk);
      f0_w1c <= '0;
   endtask

   task powerdown_request(input logic v);
      @(posedge sys_clk);
      pdr_wr    <= 1'b1;
      pdr_wdata <= v;
      @(posedge sys_clk);
      pdr_wr <= 1'b0;
   endtask

   // Bounded wait: 0 sleep ack, 1 bus active, 2 frame on wire
   task wt(input int w, input logic v, input int lim);
      int i;
      logic cur;
      for (i = 0; i <= lim; i++)
      begin
         #1;
         cur = (w == 0) ? ack_r : (w == 1) ? active_r : fbusy;
         if (cur === v)
            return;
         @(posedge sys_clk);
      end
      $display("Error wait %0d expected %b timed out", w, v);
      fail_count++;
      tally_and_finish();
   endtask

   task t_gate;
      mev(1, 3);
      chk("core_en", 32'h0, {31'h0, core_en_r});
      periph_clk_en <= 1'b1;
      tick(2);
      chk("core_en", 32'h1, {31'h0, core_en_r});
      rd(cifs_pkg::RD_FLAG0, 32'h0, 32'hFFFF_FFFF);
   endtask

   task t_mbox;
      mev(1, 8);
      rd(cifs_pkg::RD_FLAG0, 32'h0000_8008, 32'hFFFF_FFFF);
      chk("irq", 32'h1, {30'h0, irq_line_r});
      mev(0, 19);
      rd(cifs_pkg::RD_FLAG0, 32'h0000_8013, 32'hFFFF_FFFF);
      rd(cifs_pkg::RD_TA, 32'h0008_0000, 32'hFFFF_FFFF);
      mclr(0, 19);
      rd(cifs_pkg::RD_FLAG0, 32'h0000_8008, 32'hFFFF_FFFF);
      mclr(1, 8);
      rd(cifs_pkg::RD_FLAG0, 32'h0, 32'hFFFF_FFFF);
      rd(cifs_pkg::RD_RMP, 32'h0, 32'hFFFF_FFFF);
      chk("irq", 32'h0, {30'h0, irq_line_r});
      mev(1, 5);
      rd(cifs_pkg::RD_FLAG1, 32'h0000_8005, 32'hFFFF_FFFF);
      chk("irq", 32'h2, {30'h0, irq_line_r});
      mclr(1, 5);
      tick(3);
      chk("irq", 32'h0, {30'h0, irq_line_r});
   endtask

   task t_side;
      mev(1, 13);
      mev(1, 13);
      rd(cifs_pkg::RD_FLAG0, 32'h0000_880D, 32'hFFFF_FFFF);
      w1c(32'h0002_C800);
      rd(cifs_pkg::RD_FLAG0, 32'h0000_880D, 32'hFFFF_FFFF);
      mclr(1, 13);
      rd(cifs_pkg::RD_FLAG0, 32'h0, 32'hFFFF_FFFF);
      rd(cifs_pkg::RD_RML, 32'h0000_2000, 32'hFFFF_FFFF);
      mclr(3, 13);
      rd(cifs_pkg::RD_RML, 32'h0, 32'hFFFF_FFFF);
      mev(2, 13);
      rd(cifs_pkg::RD_FLAG0, 32'h0000_4000, 32'h0000_C800);
      rd(cifs_pkg::RD_AA, 32'h0000_2000, 32'hFFFF_FFFF);
      mclr(2, 13);
      rd(cifs_pkg::RD_FLAG0, 32'h0, 32'h0000_C800);
      mev(3, 27);
      rd(cifs_pkg::RD_FLAG0, 32'h0002_0000, 32'h0002_0000);
      rd(cifs_pkg::RD_TOS, 32'h0800_0000, 32'hFFFF_FFFF);
      w1c(32'h0002_0000);
      rd(cifs_pkg::RD_FLAG0, 32'h0002_0000, 32'h0002_0000);
      mclr(4, 27);
      rd(cifs_pkg::RD_FLAG0, 32'h0, 32'h0002_0000);
   endtask

   task t_sys;
      logic [31:0] left;
      left = 32'h0001_2700;
      @(posedge sys_clk);
      sys_evt <= 5'h1F;
      @(posedge sys_clk);
      sys_evt <= '0;
      rd(cifs_pkg::RD_FLAG0, left, 32'h0001_2700);
      for (int b = 8; b < 17; b++)
      begin
         if (left[b])
         begin
            left[b] = 1'b0;
            w1c(32'h1 << b);
            rd(cifs_pkg::RD_FLAG0, left, 32'h0001_2700);
         end
      end
   endtask

   task t_sleep;
      mev(1, 2);
      powerdown_request(1'b1);
      wt(0, 1'b1, 4);
      rd(cifs_pkg::RD_STATUS, 32'h0000_0008, 32'hFFFF_FFFF);
      rd(cifs_pkg::RD_RMP, 32'h0, 32'hFFFF_FFFF);
      rd(cifs_pkg::RD_FLAG0, 32'h0, 32'hFFFF_FFFF);
      go <= 1'b1;
      tick(1);
      go <= 1'b0;
      tick(50);
      chk("ack", 32'h1, {31'h0, ack_r});
      powerdown_request(1'b0);
      wt(0, 1'b0, 4);
      chk("pdr", 32'h0, {31'h0, pdr_r});
      rd(cifs_pkg::RD_FLAG0, 32'h0000_9002, 32'hFFFF_FFFF);
      w1c(32'h0000_1000);
      mclr(1, 2);
      tx_busy <= 1'b1;
      powerdown_request(1'b1);
      tick(6);
      chk("ack", 32'h0, {31'h0, ack_r});
      rd(cifs_pkg::RD_MCTL, 32'h0000_0800, 32'hFFFF_FFFF);
      rd(cifs_pkg::RD_STATUS, 32'h0, 32'hFFFF_FFFF);
      tx_busy <= 1'b0;
      wt(0, 1'b1, 4);
      powerdown_request(1'b0);
      wt(0, 1'b0, 4);
      w1c(32'h0000_1000);
   endtask

   task t_bwake;
      wake_en <= 1'b1;
      powerdown_request(1'b1);
      wt(0, 1'b1, 4);
      go <= 1'b1;
      tick(1);
      go <= 1'b0;
      wt(0, 1'b0, 40);
      chk("pdr", 32'h0, {31'h0, pdr_r});
      chk("discard", 32'h1, {31'h0, discard_r});
      wt(2, 1'b0, 60);
      repeat (10) @(posedge bit_tick);
      #1;
      chk("active", 32'h0, {31'h0, active_r});
      wt(1, 1'b1, 40);
      rd(cifs_pkg::RD_FLAG0, 32'h0000_1000, 32'h0000_1000);
      rd(cifs_pkg::RD_MCTL, 32'h0000_0080, 32'hFFFF_FFFF);
      sys_sel <= 1'b1;
      rd(cifs_pkg::RD_FLAG1, 32'h0000_1000, 32'h0000_1000);
      rd(cifs_pkg::RD_FLAG0, 32'h0, 32'h0000_1000);
   endtask

   // Reset, then scenarios in turn
   initial
   begin
      {srst, periph_clk_en, sys_sel, wake_en, pdr_wr, pdr_wdata, tx_busy, rd_en, go} = 9'h100;
      {f0_w1c, f1_w1c} = '0;
      mask = 32'hFFFF_FFFF;
      line_sel = 32'h0000_0020;
      {mbox_evt, sys_evt, mbox_clr} = '0;
      rd_sel = cifs_pkg::RD_FLAG0;
      tick(8);
      srst <= 1'b0;
      t_gate();
      t_mbox();
      t_side();
      t_sys();
      t_sleep();
      t_bwake();
      tally_and_finish();
   end
endmodule
`default_nettype wire
